// *** common/dcar_pkg.sv ***
// package for the channel code and converter register bank
// assumes a single 200 MHz clock domain and avalon-mm word addressing
package dcar_pkg;
  localparam int          ADDR_W            = 6;
  localparam int          DATA_W            = 32;
  localparam int          REG_W             = 16;
  // register indices as printed; byte address is four times the index
  localparam logic [5:0]  IDX_CH2_CODE      = 6'h19;
  localparam logic [5:0]  IDX_CH0_CODE      = 6'h1B;
  localparam logic [5:0]  IDX_CH1_CODE      = 6'h1C;
  localparam logic [5:0]  IDX_CONV_CTRL     = 6'h1D;
  localparam logic [5:0]  IDX_CONV_RESULT   = 6'h1E;
  localparam logic [5:0]  IDX_IRQ_STATUS    = 6'h28;
  localparam logic [5:0]  IDX_IRQ_MASK      = 6'h29;
  localparam logic [5:0]  IDX_SAMPLE_IN     = 6'h2A;
  // field layout
  localparam int          CODE_MSB          = 15;
  localparam int          CODE_LSB          = 4;
  localparam int          CONV_EN_BIT       = 13;
  localparam int          AVG_MSB           = 12;
  localparam int          AVG_LSB           = 11;
  localparam int          RSVD_MSB          = 10;
  localparam int          RSVD_LSB          = 1;
  localparam int          START_BIT         = 0;
  localparam int          READY_BIT         = 0;
  localparam int          RES_BITS          = 10;
  // reset values
  localparam logic [15:0] CODE_RESET        = 16'h0000;
  localparam logic [15:0] CTRL_RESET        = 16'h0000;
  localparam logic [9:0]  RSVD_REQUIRED     = 10'h1E0;
  localparam logic [1:0]  IRQ_RESET         = 2'h0;
  // interrupt status bits
  localparam int          IRQ_DONE_BIT      = 0;
  localparam int          IRQ_OVERRUN_BIT   = 1;
  localparam int          IRQ_BITS          = 2;
  localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;
  // averaging selections
  typedef enum logic [1:0] {DCAR_AVG4, DCAR_AVG8, DCAR_AVG16, DCAR_AVG32} dcar_avg_t;
endpackage

// *** logic/dcar_averager.sv ***
// converter sample averager: collects 4..32 samples, then reports the mean
// assumes samples already synchronised; one sample per valid pulse
`timescale 1ns/1ps
`default_nettype none
module dcar_averager
  import dcar_pkg::*;
(
  // clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // control
  input  wire logic                start,
  input  wire dcar_avg_t           avg_sel,
  input  wire logic                sample_valid,
  input  wire logic [RES_BITS-1:0] sample,
  // result
  output logic                     busy,
  output logic                     done,
  output logic      [RES_BITS-1:0] mean
);
  logic [RES_BITS+4:0] acc;
  logic [5:0]          count;
  logic [5:0]          target;
  logic [2:0]          shift;
  logic [RES_BITS+4:0] next_acc;

  assign shift    = 3'(avg_sel) + 3'h2;
  assign target   = 6'(6'h01 << shift);
  assign next_acc = acc + (RES_BITS + 5)'(sample);

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      busy  <= 1'b0;
      done  <= 1'b0;
      acc   <= '0;
      count <= '0;
      mean  <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        busy  <= 1'b1;
        acc   <= '0;
        count <= '0;
      end
      else if (busy && sample_valid)
      begin
        acc   <= next_acc;
        count <= count + 6'h01;
        if (count + 6'h01 == target)
        begin
          busy <= 1'b0;
          done <= 1'b1;
          mean <= RES_BITS'(next_acc >> shift);
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** logic/dcar_code_reg.sv ***
// one channel output-code register with the low ignored bits masked
// assumes write strobe from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module dcar_code_reg
  import dcar_pkg::*;
#(
  parameter int CODE_BITS = 10
)
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // write port
  input  wire logic              write_en,
  input  wire logic [REG_W-1:0]  write_data,
  // stored code
  output logic      [REG_W-1:0]  code
);
  if (CODE_BITS != 10 && CODE_BITS != 8)
    $error("code width must be 8 or 10");

  localparam logic [REG_W-1:0] KEEP_MASK =
    REG_W'(((1 << CODE_BITS) - 1) << (CODE_MSB + 1 - CODE_BITS));

  always_ff @(posedge clock)
  begin
    if (reset)
      code <= CODE_RESET;
    else if (write_en)
      code <= write_data & KEEP_MASK;
  end
endmodule
`default_nettype wire

// *** logic/dcar_regs.sv ***
// What this block does
// - three channel code registers, straight binary in bits 15..4, reset zero
// - ten-bit variant uses upper ten bits, eight-bit variant upper eight
// - control bit 13 enables channel 1 conversion, clear disables it
// - bits 12..11 pick 4, 8, 16 or 32 averaged samples
// - writing one to bit 0 starts a conversion while bit 13 is set; bit clears itself
// - ready flag resets high, drops on trigger, rises when result valid
//
// register bank top: avalon-mm slave, converter sequencing, interrupt
// assumes samples arrive from an external converter front end as pins
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcar_regs
  import dcar_pkg::*;
#(
  parameter int CODE_BITS = 10
)
(
  // clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [DATA_W-1:0]   avs_readdata,
  output logic                     avs_waitrequest,
  // converter sample pins
  input  wire logic                sample_strobe,
  input  wire logic [RES_BITS-1:0] sample_value,
  // analog side controls
  output logic      [REG_W-1:0]    ch0_code,
  output logic      [REG_W-1:0]    ch1_code,
  output logic      [REG_W-1:0]    ch2_code,
  output logic                     converter_enable,
  output logic                     result_ready_flag,
  // interrupt
  output logic                     irq
);
  if (CODE_BITS != 10 && CODE_BITS != 8)
    $error("code width must be 8 or 10");

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, answer on the second cycle of a request
  logic                acked;
  logic                req;
  logic                take;
  logic [REG_W-1:0]    wdata16;
  logic                lo_en;
  logic                hi_en;

  assign req     = avs_read | avs_write;
  assign take    = req & acked;
  assign wdata16 = avs_writedata[REG_W-1:0];
  assign lo_en   = avs_byteenable[0];
  assign hi_en   = avs_byteenable[1];

  function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old_v,
                                               input logic [REG_W-1:0] new_v,
                                               input logic lo, input logic hi);
    merge16 = {hi ? new_v[15:8] : old_v[15:8], lo ? new_v[7:0] : old_v[7:0]};
  endfunction

  always_ff @(posedge clock)
  begin
    if (reset)
      acked <= 1'b0;
    else
      acked <= req & ~acked;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~(req & ~acked);
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode
  logic hit_ch0;
  logic hit_ch1;
  logic hit_ch2;
  logic hit_ctrl;
  logic hit_result;
  logic hit_status;
  logic hit_mask;
  logic hit_sample;

  assign hit_ch0    = avs_address == IDX_CH0_CODE;
  assign hit_ch1    = avs_address == IDX_CH1_CODE;
  assign hit_ch2    = avs_address == IDX_CH2_CODE;
  assign hit_ctrl   = avs_address == IDX_CONV_CTRL;
  assign hit_result = avs_address == IDX_CONV_RESULT;
  assign hit_status = avs_address == IDX_IRQ_STATUS;
  assign hit_mask   = avs_address == IDX_IRQ_MASK;
  assign hit_sample = avs_address == IDX_SAMPLE_IN;

  logic wr_go;
  logic rd_go;
  assign wr_go = take & avs_write;
  assign rd_go = take & avs_read;

  ////////////////////////////////////////////////////////////////////////
  // channel code registers
  logic [REG_W-1:0] code0_q;
  logic [REG_W-1:0] code1_q;
  logic [REG_W-1:0] code2_q;

  dcar_code_reg #(.CODE_BITS(CODE_BITS)) u_code0
  (
    .clock      (clock),
    .reset      (reset),
    .write_en   (wr_go & hit_ch0),
    .write_data (merge16(code0_q, wdata16, lo_en, hi_en)),
    .code       (code0_q)
  );

  dcar_code_reg #(.CODE_BITS(CODE_BITS)) u_code1
  (
    .clock      (clock),
    .reset      (reset),
    .write_en   (wr_go & hit_ch1),
    .write_data (merge16(code1_q, wdata16, lo_en, hi_en)),
    .code       (code1_q)
  );

  dcar_code_reg #(.CODE_BITS(CODE_BITS)) u_code2
  (
    .clock      (clock),
    .reset      (reset),
    .write_en   (wr_go & hit_ch2),
    .write_data (merge16(code2_q, wdata16, lo_en, hi_en)),
    .code       (code2_q)
  );

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ch0_code <= CODE_RESET;
      ch1_code <= CODE_RESET;
      ch2_code <= CODE_RESET;
    end
    else
    begin
      ch0_code <= code0_q;
      ch1_code <= code1_q;
      ch2_code <= code2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // converter control
  logic [REG_W-1:0] ctrl;
  logic [REG_W-1:0] ctrl_merged;
  logic             start_req;

  assign ctrl_merged = merge16(ctrl, wdata16, lo_en, hi_en);
  // start written with a one, only while enabled
  assign start_req   = wr_go & hit_ctrl & lo_en & wdata16[START_BIT] & ctrl_merged[CONV_EN_BIT];

  // reserved bits kept as written; software owns their value
  // start bit is never stored, so it reads zero
  always_ff @(posedge clock)
  begin
    if (reset)
      ctrl <= CTRL_RESET;
    else if (wr_go & hit_ctrl)
      ctrl <= {ctrl_merged[REG_W-1:1], 1'b0};
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      converter_enable <= 1'b0;
    else
      converter_enable <= ctrl[CONV_EN_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // sample value passes two flip-flops, the strobe three
  logic                strobe_s1;
  logic                strobe_s2;
  logic                strobe_s3;
  logic [RES_BITS-1:0] value_s1;
  logic [RES_BITS-1:0] value_s2;
  logic                sample_pulse;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
      value_s1  <= '0;
      value_s2  <= '0;
    end
    else
    begin
      strobe_s1 <= sample_strobe;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
      value_s1  <= sample_value;
      value_s2  <= value_s1;
    end
  end

  // value is expected stable around the strobe's rising edge
  assign sample_pulse = strobe_s2 & ~strobe_s3;

  ////////////////////////////////////////////////////////////////////////
  // averaging and result
  logic                avg_busy;
  logic                avg_done;
  logic [RES_BITS-1:0] avg_mean;
  logic [RES_BITS-1:0] result;

  dcar_averager u_avg
  (
    .clock        (clock),
    .reset        (reset),
    .start        (start_req),
    .avg_sel      (dcar_avg_t'(ctrl[AVG_MSB:AVG_LSB])),
    .sample_valid (sample_pulse & converter_enable),
    .sample       (value_s2),
    .busy         (avg_busy),
    .done         (avg_done),
    .mean         (avg_mean)
  );

  always_ff @(posedge clock)
  begin
    if (reset)
      result <= '0;
    else if (avg_done)
      result <= avg_mean;
  end

  // ready falls on trigger, rises on new result
  always_ff @(posedge clock)
  begin
    if (reset)
      result_ready_flag <= 1'b1;
    else if (start_req)
      result_ready_flag <= 1'b0;
    else if (avg_done)
      result_ready_flag <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt: done and overrun (start while busy), cleared on status read
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [IRQ_BITS-1:0] irq_events;

  assign irq_events = {start_req & avg_busy, avg_done};

  // set wins over the read clear; only bits already returned are cleared
  always_ff @(posedge clock)
  begin
    if (reset)
      irq_status <= IRQ_RESET;
    else if (rd_go & hit_status)
      irq_status <= (irq_status & ~avs_readdata[IRQ_BITS-1:0]) | irq_events;
    else
      irq_status <= irq_status | irq_events;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      irq_mask <= IRQ_RESET;
    else if (wr_go & hit_mask & lo_en)
      irq_mask <= avs_writedata[IRQ_BITS-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux
  logic [REG_W-1:0]  result_word;
  logic [DATA_W-1:0] rd_mux;

  // result left aligned, five ignored bits zero
  assign result_word = {result, 5'h00, result_ready_flag};

  always_comb
  begin
    if (hit_ch0)
      rd_mux = DATA_W'(code0_q);
    else if (hit_ch1)
      rd_mux = DATA_W'(code1_q);
    else if (hit_ch2)
      rd_mux = DATA_W'(code2_q);
    else if (hit_ctrl)
      rd_mux = DATA_W'(ctrl);
    else if (hit_result)
      rd_mux = DATA_W'(result_word);
    else if (hit_status)
      rd_mux = DATA_W'(irq_status);
    else if (hit_mask)
      rd_mux = DATA_W'(irq_mask);
    else if (hit_sample)
      rd_mux = DATA_W'({avg_busy, strobe_s2});
    else
      rd_mux = UNMAPPED_READ;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      avs_readdata <= '0;
    else if (req & ~acked)
      avs_readdata <= rd_mux;
  end
endmodule
`default_nettype wire

// *** verification/dcar_regs_sva.sv ***
// concurrent checks on the register bank top ports
// assumes one clock domain; bound into every dcar_regs instance
`timescale 1ns/1ps
`default_nettype none
module dcar_regs_sva
  import dcar_pkg::*;
#(
  parameter int CODE_BITS = 10
)
(
  // clock, reset and bus
  input wire logic                clock,
  input wire logic                reset,
  input wire logic [ADDR_W-1:0]   avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [DATA_W-1:0]   avs_writedata,
  input wire logic [3:0]          avs_byteenable,
  input wire logic [DATA_W-1:0]   avs_readdata,
  input wire logic                avs_waitrequest,
  // pins and outputs
  input wire logic                sample_strobe,
  input wire logic [RES_BITS-1:0] sample_value,
  input wire logic [REG_W-1:0]    ch0_code,
  input wire logic [REG_W-1:0]    ch1_code,
  input wire logic [REG_W-1:0]    ch2_code,
  input wire logic                converter_enable,
  input wire logic                result_ready_flag,
  input wire logic                irq
);
  localparam logic [15:0] LOW_MASK = 16'hFFFF >> CODE_BITS;
  wire logic        wr_ok = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
  wire logic        rd_ok = avs_read && !avs_waitrequest;
  logic      [15:0] held_wd;
  // keeps the accepted write data, since the consequent looks later
  always_ff @(posedge clock)
    if (wr_ok)
      held_wd <= avs_writedata[15:0];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_code_reset: assert property ($fell(reset) |-> (ch0_code | ch1_code | ch2_code) == 16'h0000)
    else $error("code outputs not zero after reset");
  a_code_lowbits: assert property (((ch0_code | ch1_code | ch2_code) & LOW_MASK) == 16'h0000)
    else $error("ignored code bits not zero");
  a_code_write: assert property (wr_ok && avs_address == IDX_CH1_CODE
    |-> ##[1:2] ch1_code == (held_wd & ~LOW_MASK)) else $error("code write not seen on output");
  a_enable_follow: assert property (wr_ok && avs_address == IDX_CONV_CTRL
    |-> ##[1:2] converter_enable == held_wd[CONV_EN_BIT]) else $error("enable does not follow bit 13");
  a_start_drops: assert property (wr_ok && avs_address == IDX_CONV_CTRL && avs_writedata[13]
    && avs_writedata[0] |-> ##[1:2] !result_ready_flag) else $error("ready flag not cleared by start");
  a_ready_reset: assert property ($fell(reset) |-> result_ready_flag)
    else $error("ready flag low after reset");
  a_trig_readzero: assert property (rd_ok && avs_address == IDX_CONV_CTRL
    |-> avs_readdata[0] == 1'b0 && avs_readdata[31:16] == 16'h0000) else $error("trigger bit read as one");
  a_result_pad: assert property (rd_ok && avs_address == IDX_CONV_RESULT
    |-> (avs_readdata[15:0] & 16'h003E) == 16'h0000) else $error("ignored result bits not zero");
endmodule
bind dcar_regs dcar_regs_sva #(.CODE_BITS(CODE_BITS)) dcar_regs_sva_i (.clock(clock), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sample_strobe(sample_strobe), .sample_value(sample_value), .ch0_code(ch0_code), .ch1_code(ch1_code),
  .ch2_code(ch2_code), .converter_enable(converter_enable), .result_ready_flag(result_ready_flag), .irq(irq));
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the register bank top
// assumes the checker file is compiled alongside; one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dcar_pkg::*;
  localparam logic [15:0] KEEP = ~(16'hFFFF >> 10);
  logic              clock, reset, avs_read, avs_write, sample_strobe, irq;
  logic              converter_enable, result_ready_flag, avs_waitrequest;
  logic [5:0]        avs_address;
  logic [31:0]       avs_writedata, avs_readdata;
  logic [3:0]        avs_byteenable;
  logic [9:0]        sample_value;
  logic [15:0]       ch0_code, ch1_code, ch2_code;
  int                failures, comparisons;
  dcar_regs #(.CODE_BITS(10)) dcar_regs_i (.clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_strobe(sample_strobe),
    .sample_value(sample_value), .ch0_code(ch0_code), .ch1_code(ch1_code), .ch2_code(ch2_code),
    .converter_enable(converter_enable), .result_ready_flag(result_ready_flag), .irq(irq));
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // the request holds until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d, input logic [3:0] be,
                     output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    rd = avs_readdata;
    if (n == 50)
      check("waitrequest", 32'h0, 32'h1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'hF, x);
  endtask
  task automatic rchk(input string what, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 16'h0000, 4'hF, x);
    check(what, exp, x);
  endtask
  task automatic sample(input logic [9:0] v);
    sample_value <= v;
    @(posedge clock);
    sample_strobe <= 1'b1;
    repeat (2) @(posedge clock);
    sample_strobe <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("code ports", 32'h0, {ch0_code, ch1_code | ch2_code});
    check("ready irq", 32'h1, {30'h0, irq, result_ready_flag});
    rchk("ch2", IDX_CH2_CODE, 32'h0);
    rchk("ch0", IDX_CH0_CODE, 32'h0);
    rchk("ch1", IDX_CH1_CODE, 32'h0);
    rchk("ctrl", IDX_CONV_CTRL, 32'h0);
    rchk("result", IDX_CONV_RESULT, 32'h1);
    rchk("unmapped", 6'h3F, UNMAPPED_READ);
    rchk("mask", IDX_IRQ_MASK, 32'h0);
  endtask
  task automatic t_codes;
    logic [5:0]  idx [3];
    logic [15:0] pat [3];
    logic [31:0] x;
    idx = '{IDX_CH0_CODE, IDX_CH1_CODE, IDX_CH2_CODE};
    pat = '{16'hA5A5, 16'hFFFF, 16'h003F};
    for (int i = 0; i < 3; i++)
    begin
      wr(idx[i], pat[i]);
      rchk("code", idx[i], {16'h0, pat[i] & KEEP});
      check("code port", {16'h0, pat[i] & KEEP}, {16'h0, i == 0 ? ch0_code : i == 1 ? ch1_code : ch2_code});
    end
    rchk("ch0 kept", IDX_CH0_CODE, 32'hA580);
    bus(1'b1, IDX_CH0_CODE, 16'h0000, 4'h2, x);
    wr(6'h3F, 16'hFFFF);
    rchk("ch0 lane", IDX_CH0_CODE, 32'h0080);
    rchk("unmapped", 6'h3F, UNMAPPED_READ);
  endtask
  task automatic t_control;
    wr(IDX_CONV_CTRL, 16'h33C0);
    rchk("ctrl", IDX_CONV_CTRL, 32'h33C0);
    check("enable", 32'h1, {31'h0, converter_enable});
    wr(IDX_CONV_CTRL, 16'h03C1);
    rchk("ctrl", IDX_CONV_CTRL, 32'h03C0);
    check("enable", 32'h0, {31'h0, converter_enable});
    check("ready idle", 32'h1, {31'h0, result_ready_flag});
  endtask
  task automatic t_convert(input logic [1:0] avg, input logic [9:0] v);
    int          n;
    logic [15:0] cw;
    n = 4 << avg;
    cw = 16'h23C1 | {3'b000, avg, 11'h000};
    // channel 1 comparator mode lies outside this block, taken as set
    wr(IDX_CONV_CTRL, cw);
    check("ready low", 32'h0, {31'h0, result_ready_flag});
    rchk("trigger", IDX_CONV_CTRL, {16'h0, cw & 16'hFFFE});
    for (int k = 0; k < n; k++)
    begin
      sample(v + 10'(2 * (k % 2)));
      if (k == n - 2)
        check("early", 32'h0, {31'h0, result_ready_flag});
    end
    // software waits on the ready flag before taking the result
    for (int k = 0; k < 20 && result_ready_flag !== 1'b1; k++)
      @(posedge clock);
    rchk("result", IDX_CONV_RESULT, {16'h0, v + 10'h001, 6'h01});
  endtask
  task automatic t_irq;
    rchk("status", IDX_IRQ_STATUS, 32'h1);
    rchk("status clr", IDX_IRQ_STATUS, 32'h0);
    wr(IDX_IRQ_MASK, 16'h0001);
    rchk("mask", IDX_IRQ_MASK, 32'h1);
    t_convert(2'b00, 10'h3FD);
    check("irq on", 32'h1, {31'h0, irq});
    rchk("status", IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clock);
    check("irq off", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_MASK, 16'h0000);
    t_convert(2'b00, 10'h000);
    check("irq masked", 32'h0, {31'h0, irq});
    rchk("status", IDX_IRQ_STATUS, 32'h1);
    // a second start while the first still averages flags an overrun
    wr(IDX_CONV_CTRL, 16'h23C1);
    wr(IDX_CONV_CTRL, 16'h23C1);
    rchk("overrun", IDX_IRQ_STATUS, 32'h2);
    rchk("busy", IDX_SAMPLE_IN, 32'h2);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    {reset, avs_read, avs_write, sample_strobe} = 4'h8;
    {avs_address, avs_writedata, avs_byteenable, sample_value} = '0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset;
    t_codes;
    t_control;
    for (int a = 0; a < 4; a++)
      t_convert(2'(a), 10'h200 + 10'(a * 85));
    t_irq;
    report_and_stop;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    report_and_stop;
  end
endmodule
`default_nettype wire
